// ---- verilog/dsmc_top.sv ----
// Serial DAC mode control core: code register, power-down and wake
//
// Functional notes
// - Frame bits 17 and 16 form the mode field, 00 meaning normal drive.
// - Modes 01, 10, 11 select 1 k to ground, 100 k to ground, high-Z.
// - In power-down the analog part is off and the output goes to the selected load, or high-Z in mode 11.
// - Power-down never alters the stored code.
// - Reset clears the code and holds 0 V until a full frame arrives.
// - The code is unsigned binary, 16 or 12 bits wide.
// - On leaving power-down the output is valid only after a recovery time.
// - A frame is 24 bits MSB first: 6 ignored, 2 mode, 16 left-aligned data.
// - Sync falling starts a frame, data taken on clock falls, update on 24th.
// - Sync rising before the 24th fall discards the frame.
`timescale 1ns/1ps
module dsmc_top #(
   parameter int CODE_W = dsmc_pkg::CODE_W_16,
   parameter bit LOW_SUPPLY = 1'b0
) (
   input wire logic SYS_CLK_I,
   input wire logic SRST_I,
   input wire logic SCLK_I,
   input wire logic SYNC_N_I,
   input wire logic DIN_I,
   output logic [CODE_W-1:0] DAC_CODE_O,
   output dsmc_pkg::dsmc_mode_type MODE_O,
   output logic AMP_EN_O,
   output logic TERM_1K_O,
   output logic TERM_100K_O,
   output logic OUT_VALID_O
);
   import dsmc_pkg::*;

   localparam int WAKE_CYC = LOW_SUPPLY ? WAKE_3V_CYC : WAKE_5V_CYC;

   logic [FRAME_BITS-1:0] frame;
   logic frame_tgl;

   dsmc_shift u_shift (
      .rst_i(SRST_I),
      .sclk_i(SCLK_I),
      .sync_n_i(SYNC_N_I),
      .din_i(DIN_I),
      .frame_o(frame),
      .frame_tgl_o(frame_tgl)
   );

   // ----------------------------------------------------------------
   // Toggle crossing, three stages
   // ----------------------------------------------------------------
   logic [2:0] tgl_s_q, tgl_s_d;
   logic tgl_seen_q, tgl_seen_d;
   logic new_frame;

   always_comb begin
      tgl_s_d = {tgl_s_q[1:0], frame_tgl};
      tgl_seen_d = tgl_seen_q;
      new_frame = 1'b0;
      if (tgl_s_q[2] == tgl_s_q[1] && tgl_s_q[2] != tgl_seen_q) begin
         new_frame = 1'b1;
         tgl_seen_d = tgl_s_q[2];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         tgl_s_q <= 3'h0;
         tgl_seen_q <= 1'b0;
      end else begin
         tgl_s_q <= tgl_s_d;
         tgl_seen_q <= tgl_seen_d;
      end
   end

   // Masks frame take for one cycle after reset release so a stale toggle is ignored
   logic armed_q, armed_d;

   // ----------------------------------------------------------------
   // Frame hand-off into the system domain
   // ----------------------------------------------------------------
   // Link side holds the word until the next 24th fall
   logic [FRAME_BITS-1:0] frame_s_q, frame_s_d;
   logic take_q, take_d;

   // Any mode but normal parks the amplifier
   function automatic logic is_pwrdn(input dsmc_mode_type m);
      return m != DSMC_NORMAL;
   endfunction

   always_comb begin
      frame_s_d = frame_s_q;
      take_d = 1'b0;
      if (new_frame && armed_q) begin
         frame_s_d = frame;
         take_d = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         frame_s_q <= '0;
         take_q <= 1'b0;
      end else begin
         frame_s_q <= frame_s_d;
         take_q <= take_d;
      end
   end

   // ----------------------------------------------------------------
   // Code and mode registers
   // ----------------------------------------------------------------
   logic [CODE_W-1:0] code_q, code_d;
   dsmc_mode_type mode_q, mode_d;
   logic [1:0] pd_field;
   logic pwrdn_sel_hi, pwrdn_sel_lo;
   logic [CODE_W-1:0] frame_code;

   assign pwrdn_sel_hi = frame_s_q[PD_HI_POS];
   assign pwrdn_sel_lo = frame_s_q[PD_LO_POS];
   assign pd_field = {pwrdn_sel_hi, pwrdn_sel_lo};
   // Left aligned; 12-bit variant drops the four padding zeros
   assign frame_code = frame_s_q[DATA_HI_POS -: CODE_W];

   always_comb begin
      code_d = code_q;
      mode_d = mode_q;
      armed_d = 1'b1;
      if (take_q) begin
         mode_d = dsmc_mode_type'(pd_field);
         if (!is_pwrdn(dsmc_mode_type'(pd_field))) begin
            code_d = frame_code;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         code_q <= '0;
         mode_q <= DSMC_NORMAL;
         armed_q <= 1'b0;
      end else begin
         code_q <= code_d;
         mode_q <= mode_d;
         armed_q <= armed_d;
      end
   end

   // ----------------------------------------------------------------
   // Wake timer
   // ----------------------------------------------------------------
   logic [WAKE_W-1:0] wake_q, wake_d;

   always_comb begin
      wake_d = wake_q;
      if (is_pwrdn(mode_q)) begin
         wake_d = WAKE_W'(WAKE_CYC);
      end else if (wake_q != '0) begin
         wake_d = wake_q - 8'h01;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         wake_q <= '0;
      end else begin
         wake_q <= wake_d;
      end
   end

   // ----------------------------------------------------------------
   // Output stage controls
   // ----------------------------------------------------------------
   logic [CODE_W-1:0] dac_code_q, dac_code_d;
   dsmc_mode_type mode_o_q, mode_o_d;
   logic amp_q, amp_d;
   logic t1k_q, t1k_d;
   logic t100k_q, t100k_d;
   logic valid_q, valid_d;

   always_comb begin
      dac_code_d = code_q;
      mode_o_d = mode_q;
      amp_d = 1'b0;
      t1k_d = 1'b0;
      t100k_d = 1'b0;
      valid_d = 1'b0;
      case (mode_q)
         DSMC_NORMAL: begin
            amp_d = 1'b1;
            valid_d = (wake_q == '0);
         end
         DSMC_PD_1K: begin
            t1k_d = 1'b1;
         end
         DSMC_PD_100K: begin
            t100k_d = 1'b1;
         end
         DSMC_PD_HIZ: begin
            amp_d = 1'b0;
         end
         default: begin
            amp_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         dac_code_q <= '0;
         mode_o_q <= DSMC_NORMAL;
         amp_q <= 1'b1;
         t1k_q <= 1'b0;
         t100k_q <= 1'b0;
         valid_q <= 1'b1;
      end else begin
         dac_code_q <= dac_code_d;
         mode_o_q <= mode_o_d;
         amp_q <= amp_d;
         t1k_q <= t1k_d;
         t100k_q <= t100k_d;
         valid_q <= valid_d;
      end
   end

   assign DAC_CODE_O = dac_code_q;
   assign MODE_O = mode_o_q;
   assign AMP_EN_O = amp_q;
   assign TERM_1K_O = t1k_q;
   assign TERM_100K_O = t100k_q;
   assign OUT_VALID_O = valid_q;
endmodule

// ---- verilog/dsmc_pkg.sv ----
// Constants and types for the serial DAC mode control core
package dsmc_pkg;
   localparam int FRAME_BITS = 24;
   localparam int CNT_W = 5;
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam int PD_HI_POS = 17;
   localparam int PD_LO_POS = 16;
   localparam int DATA_HI_POS = 15;
   localparam int CODE_W_16 = 16;
   localparam int CODE_W_12 = 12;
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
   // Recovery times in ns
   localparam int WAKE_5V_NS = 2500;
   localparam int WAKE_3V_NS = 5000;
   localparam int WAKE_5V_CYC = (WAKE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_3V_CYC = (WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_W = 8;

   typedef enum logic [1:0] {
      DSMC_NORMAL = 2'b00,
      DSMC_PD_1K = 2'b01,
      DSMC_PD_100K = 2'b10,
      DSMC_PD_HIZ = 2'b11
   } dsmc_mode_type;
endpackage

// ---- verilog/dsmc_shift.sv ----
// Link-clock frame shifter, 24-bit frame capture and toggle hand-off
`timescale 1ns/1ps
module dsmc_shift (
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic din_i,
   output logic [dsmc_pkg::FRAME_BITS-1:0] frame_o,
   output logic frame_tgl_o
);
   import dsmc_pkg::*;

   logic [FRAME_BITS-1:0] sh_q, sh_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [FRAME_BITS-1:0] frame_q, frame_d;
   logic tgl_q, tgl_d;
   logic done_q, done_d;

   // ----------------------------------------------------------------
   // Shift and count
   // ----------------------------------------------------------------
   always_comb begin
      sh_d = sh_q;
      cnt_d = cnt_q;
      frame_d = frame_q;
      tgl_d = tgl_q;
      done_d = done_q;
      if (!done_q) begin
         sh_d = {sh_q[FRAME_BITS-2:0], din_i};
         cnt_d = cnt_q + 5'h01;
         if (cnt_q == LAST_BIT) begin
            frame_d = {sh_q[FRAME_BITS-2:0], din_i};
            tgl_d = ~tgl_q;
            done_d = 1'b1;
         end
      end
   end

   // Sync high or system reset clears the frame state at once
   always_ff @(negedge sclk_i or posedge sync_n_i or posedge rst_i) begin
      if (sync_n_i || rst_i) begin
         sh_q <= '0;
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   // Captured frame survives sync rising; link clock idles in reset
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_q <= '0;
         tgl_q <= 1'b0;
      end else begin
         frame_q <= frame_d;
         tgl_q <= tgl_d;
      end
   end

   assign frame_o = frame_q;
   assign frame_tgl_o = tgl_q;
endmodule

// ---- tb/dsmc_host.sv ----
// Host serial port model sending 24-bit frames
`timescale 1ns/1ps
module dsmc_host (
   output logic sclk_o,
   output logic sync_n_o,
   output logic din_o
);
   initial begin
      sclk_o = 1'b1;
      sync_n_o = 1'b1;
      din_o = 1'b0;
   end
   // Sends the top n bits, fewer than 24 aborts
   task automatic send(input logic [23:0] w, input int n);
      sync_n_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         din_o = w[23-k];
         #80 sclk_o = 1'b0;
         #80 sclk_o = 1'b1;
      end
      #80 sync_n_o = 1'b1;
      din_o = ~din_o;
      #200;
   endtask
endmodule

// ---- tb/dsmc_top_sva.sv ----
// Port assertions for the serial DAC mode control core
`timescale 1ns/1ps
module dsmc_top_sva #(
   parameter int CODE_W = dsmc_pkg::CODE_W_16,
   parameter bit LOW_SUPPLY = 1'b0
) (
   input wire logic SYS_CLK_I,
   input wire logic SRST_I,
   input wire logic SYNC_N_I,
   input wire logic [CODE_W-1:0] DAC_CODE_O,
   input wire dsmc_pkg::dsmc_mode_type MODE_O,
   input wire logic AMP_EN_O,
   input wire logic TERM_1K_O,
   input wire logic TERM_100K_O,
   input wire logic OUT_VALID_O
);
   import dsmc_pkg::*;
   localparam int W = LOW_SUPPLY ? WAKE_3V_CYC : WAKE_5V_CYC;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (SRST_I);
   // Counts wake cycles since the amplifier came on
   always_comb begin
      cnt_d = AMP_EN_O ? cnt_q + {7'h00, !OUT_VALID_O} : 8'h00;
   end
   always_ff @(posedge SYS_CLK_I) begin
      cnt_q <= SRST_I ? 8'h00 : cnt_d;
   end
   a_reset_zero: assert property (
      $past(SRST_I) |-> DAC_CODE_O == '0 && MODE_O == DSMC_NORMAL)
      else $error("reset state wrong");
   a_amp_mode: assert property (
      $stable(MODE_O) |-> AMP_EN_O == (MODE_O == DSMC_NORMAL))
      else $error("amplifier enable wrong");
   a_term_sel: assert property (
      $stable(MODE_O) |-> TERM_1K_O == (MODE_O == DSMC_PD_1K) &&
      TERM_100K_O == (MODE_O == DSMC_PD_100K))
      else $error("termination wrong");
   a_code_keep: assert property (
      $changed(DAC_CODE_O) |-> MODE_O == DSMC_NORMAL)
      else $error("code changed in power-down");
   a_frame_cause: assert property (
      $changed(DAC_CODE_O) || $changed(MODE_O) |-> !$past(SYNC_N_I, 7))
      else $error("update without frame");
   a_wake_time: assert property (
      $rose(OUT_VALID_O) |-> cnt_q >= W - 1 && cnt_q <= W + 3)
      else $error("wake time wrong");
   a_valid_pd: assert property (
      $stable(MODE_O) && MODE_O != DSMC_NORMAL |-> !OUT_VALID_O)
      else $error("valid in power-down");
   a_wake_low: assert property (
      $rose(AMP_EN_O) |-> !OUT_VALID_O [*8])
      else $error("valid too early");
   c_hiz: cover property (MODE_O == DSMC_PD_HIZ);
   c_wake: cover property ($rose(OUT_VALID_O));
   c_code: cover property ($changed(DAC_CODE_O));
endmodule
bind dsmc_top dsmc_top_sva #(.CODE_W(CODE_W), .LOW_SUPPLY(LOW_SUPPLY)) u_sva (
   .SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .SYNC_N_I(SYNC_N_I),
   .DAC_CODE_O(DAC_CODE_O), .MODE_O(MODE_O), .AMP_EN_O(AMP_EN_O),
   .TERM_1K_O(TERM_1K_O), .TERM_100K_O(TERM_100K_O),
   .OUT_VALID_O(OUT_VALID_O));

// ---- tb/test_dsmc_top.sv ----
// Self-checking bench for the serial DAC mode control core
`timescale 1ns/1ps
module test_dsmc_top;
   import dsmc_pkg::*;
   logic clk = 1'b0;
   logic srst;
   wire sclk, sync_n, din;
   logic [15:0] code;
   dsmc_mode_type mode;
   logic amp, t1k, t100k, vld;
   logic [21:0] exp_q[$];
   logic [31:0] seed = 32'h57;
   logic [15:0] code_e = 16'h0000;
   logic [1:0] mode_e = 2'h0;
   int bad_count = 0;
   int n_tests = 0;
   event note;
   initial forever #50 clk = ~clk;
   dsmc_top u_dsmc_top (.SYS_CLK_I(clk), .SRST_I(srst), .SCLK_I(sclk),
      .SYNC_N_I(sync_n), .DIN_I(din), .DAC_CODE_O(code), .MODE_O(mode),
      .AMP_EN_O(amp), .TERM_1K_O(t1k), .TERM_100K_O(t100k),
      .OUT_VALID_O(vld));
   dsmc_host u_dsmc_host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [21:0] got, input logic [21:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Lets the wake time pass, then notes the expected outputs
   task automatic settle();
      repeat (40) @(posedge clk);
      exp_q.push_back({code_e, mode_e, mode_e == 2'h0, mode_e == 2'h1,
         mode_e == 2'h2, mode_e == 2'h0});
      -> note;
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial forever begin
      @note;
      @(negedge clk);
      check({code, mode, amp, t1k, t100k, vld}, exp_q.pop_front());
   end
   initial begin
      int n;
      logic [31:0] r;
      srst <= 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      settle();
      for (int i = 0; i < 24; i++) begin
         r = xs();
         n = (i % 6 == 5) ? i : 24;
         u_dsmc_host.send({r[31:26], i[1:0], r[15:0]}, n);
         if (n == 24) begin
            mode_e = i[1:0];
            if (i[1:0] == 2'h0) code_e = r[15:0];
         end
         settle();
      end
      test_done();
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      test_done();
   end
endmodule
